// >>> rfi_consts.svh
// constants of the rf front-end interrupt flag block
// Contract
// - target mask resets zero, bit2 reserved
// - oscillator stable sets main bit 7 when enabled
// - receive fifo above 300 sets level flag
// - transmit fifo below 200 sets level flag
// - main holds rx start/end, tx end, collision
// - disturbance frame discard sets main bit 1
// - reading timer register clears it
// - reading main register clears error register
// - command done, no-response, timer expiry bits
// - field rise bit 4, field fall bit 3
// - field switched on after guard sets bit 1
// - target bit rate recognised sets bit 0
// - crc, parity, soft framing error bits
// - hard framing error sets bit 4
// - wake timeout sets bit 3 when enabled
// - amplitude change over reference sets bit 2
// - phase change over reference sets bit 1
// - capacitance change over reference sets bit 0
// - each flag has mask bit, one masks
// - target flags set by events, read clears
`ifndef RFI_CONSTS_SVH
`define RFI_CONSTS_SVH

// ----------------------------------------
// register indices, byte address is index times four
// ----------------------------------------
`define RFI_IDX_MASK_MAIN 8'h16
`define RFI_IDX_MASK_TMR 8'h17
`define RFI_IDX_MASK_ERR 8'h18
`define RFI_IDX_MASK_TGT 8'h19
`define RFI_IDX_MAIN 8'h1a
`define RFI_IDX_TMR 8'h1b
`define RFI_IDX_ERR 8'h1c
`define RFI_IDX_TGT 8'h1d
`define RFI_IDX_CTRL 8'h3f

// ----------------------------------------
// reset values and reserved masks
// ----------------------------------------
`define RFI_RST_BYTE 8'h00
`define RFI_MAIN_USED 8'hfe
`define RFI_TGT_USED 8'hfb
`define RFI_CTRL_USED 8'h03

// ----------------------------------------
// field positions
// ----------------------------------------
`define RFI_CTRL_OSC_EN 0
`define RFI_CTRL_WAKE_EVERY 1
`define RFI_B7 7
`define RFI_B6 6
`define RFI_B5 5
`define RFI_B4 4
`define RFI_B3 3
`define RFI_B2 2
`define RFI_B1 1
`define RFI_B0 0

// ----------------------------------------
// fifo water levels
// ----------------------------------------
`define RFI_WL_RX_LIMIT 10'h12c
`define RFI_WL_TX_LIMIT 10'h0c8

`endif

// >>> rfi_flags.sv
// interrupt flags, masks and wishbone slave of the rf front end
`timescale 1ns/1ps
`default_nettype none
`include "rfi_consts.svh"

module rfi_flags
    import rfi_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic osc_stable_i,
    input wire logic rx_active_i,
    input wire logic tx_active_i,
    input wire logic [9:0] fifo_count_i,
    input wire logic rx_start_i,
    input wire logic rx_end_i,
    input wire logic tx_end_i,
    input wire logic bit_collision_i,
    input wire logic disturbance_frame_i,
    input wire logic cmd_done_i,
    input wire logic nrt_expire_i,
    input wire logic gpt_expire_i,
    input wire logic ext_field_i,
    input wire logic ca_collision_i,
    input wire logic ca_guard_done_i,
    input wire logic target_mode_i,
    input wire logic bitrate_found_i,
    input wire logic crc_err_i,
    input wire logic parity_err_i,
    input wire logic soft_framing_i,
    input wire logic hard_framing_i,
    input wire logic wake_timeout_i,
    input wire logic wake_meas_i,
    input wire logic [7:0] amp_delta_i,
    input wire logic [7:0] amp_ref_i,
    input wire logic [7:0] phase_delta_i,
    input wire logic [7:0] phase_ref_i,
    input wire logic [7:0] cap_delta_i,
    input wire logic [7:0] cap_ref_i,
    input wire logic [7:0] target_event_i
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // event set wins over a clear in the same cycle
    function automatic rfi_byte_t set_clr(input rfi_byte_t cur, input rfi_byte_t set,
                                          input logic clr);
        set_clr = (clr ? `RFI_RST_BYTE : cur) | set;
    endfunction

    function automatic logic exceeds(input rfi_byte_t delta, input rfi_byte_t ref_v);
        exceeds = delta > ref_v;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    rfi_byte_t mask_main_ff, mask_tmr_ff, mask_err_ff, mask_tgt_ff, ctrl_ff;
    rfi_byte_t main_ff, tmr_ff, err_ff, tgt_ff;
    rfi_byte_t nxt_main, nxt_tmr, nxt_err, nxt_tgt;
    rfi_byte_t main_set, tmr_set, err_set, tgt_set, rd_byte;
    logic osc_prev_ff, field_prev_ff, ack_ff, irq_ff;
    logic [31:0] dat_ff;
    logic bus_req, wr_hit, rd_hit, rd_main, rd_tmr, rd_err, rd_tgt;
    rfi_idx_t idx;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    assign idx = wb_adr_i[9:2];
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr_hit = bus_req & wb_we_i & wb_sel_i[0];
    assign rd_hit = bus_req & ~wb_we_i;
    assign rd_main = rd_hit & (idx == `RFI_IDX_MAIN);
    assign rd_tmr = rd_hit & (idx == `RFI_IDX_TMR);
    assign rd_err = rd_hit & (idx == `RFI_IDX_ERR);
    assign rd_tgt = rd_hit & (idx == `RFI_IDX_TGT);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req;
        end
    end

    always_comb begin
        case (idx)
            `RFI_IDX_MASK_MAIN: rd_byte = mask_main_ff;
            `RFI_IDX_MASK_TMR: rd_byte = mask_tmr_ff;
            `RFI_IDX_MASK_ERR: rd_byte = mask_err_ff;
            `RFI_IDX_MASK_TGT: rd_byte = mask_tgt_ff;
            `RFI_IDX_MAIN: rd_byte = main_ff;
            `RFI_IDX_TMR: rd_byte = tmr_ff;
            `RFI_IDX_ERR: rd_byte = err_ff;
            `RFI_IDX_TGT: rd_byte = tgt_ff;
            `RFI_IDX_CTRL: rd_byte = ctrl_ff;
            default: rd_byte = `RFI_RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= 32'h0000_0000;
        end else if (rd_hit) begin
            dat_ff <= {24'h00_0000, rd_byte};
        end
    end

    // ----------------------------------------
    // mask and control registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_main_ff <= `RFI_RST_BYTE;
            mask_tmr_ff <= `RFI_RST_BYTE;
            mask_err_ff <= `RFI_RST_BYTE;
            mask_tgt_ff <= `RFI_RST_BYTE;
            ctrl_ff <= `RFI_RST_BYTE;
        end else if (wr_hit) begin
            case (idx)
                `RFI_IDX_MASK_MAIN: mask_main_ff <= wb_dat_i[7:0] & `RFI_MAIN_USED;
                `RFI_IDX_MASK_TMR: mask_tmr_ff <= wb_dat_i[7:0];
                `RFI_IDX_MASK_ERR: mask_err_ff <= wb_dat_i[7:0];
                `RFI_IDX_MASK_TGT: mask_tgt_ff <= wb_dat_i[7:0] & `RFI_TGT_USED;
                `RFI_IDX_CTRL: ctrl_ff <= wb_dat_i[7:0] & `RFI_CTRL_USED;
                default: ctrl_ff <= ctrl_ff;
            endcase
        end
    end

    // ----------------------------------------
    // edge memories
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_prev_ff <= 1'b0;
            field_prev_ff <= 1'b0;
        end else begin
            osc_prev_ff <= osc_stable_i;
            field_prev_ff <= ext_field_i;
        end
    end

    // ----------------------------------------
    // event sets
    // ----------------------------------------
    always_comb begin
        main_set = `RFI_RST_BYTE;
        main_set[`RFI_B7] = osc_stable_i & ~osc_prev_ff & ctrl_ff[`RFI_CTRL_OSC_EN];
        main_set[`RFI_B6] = (rx_active_i & (fifo_count_i > `RFI_WL_RX_LIMIT))
                          | (tx_active_i & (fifo_count_i < `RFI_WL_TX_LIMIT));
        main_set[`RFI_B5] = rx_start_i;
        main_set[`RFI_B4] = rx_end_i;
        main_set[`RFI_B3] = tx_end_i;
        main_set[`RFI_B2] = bit_collision_i;
        main_set[`RFI_B1] = disturbance_frame_i;
        tmr_set = `RFI_RST_BYTE;
        tmr_set[`RFI_B7] = cmd_done_i;
        tmr_set[`RFI_B6] = nrt_expire_i;
        tmr_set[`RFI_B5] = gpt_expire_i;
        tmr_set[`RFI_B4] = ext_field_i & ~field_prev_ff;
        tmr_set[`RFI_B3] = ~ext_field_i & field_prev_ff;
        tmr_set[`RFI_B2] = ca_collision_i;
        tmr_set[`RFI_B1] = ca_guard_done_i;
        tmr_set[`RFI_B0] = target_mode_i & bitrate_found_i;
        err_set = `RFI_RST_BYTE;
        err_set[`RFI_B7] = crc_err_i;
        err_set[`RFI_B6] = parity_err_i;
        err_set[`RFI_B5] = soft_framing_i;
        err_set[`RFI_B4] = hard_framing_i;
        err_set[`RFI_B3] = wake_timeout_i & ctrl_ff[`RFI_CTRL_WAKE_EVERY];
        err_set[`RFI_B2] = wake_meas_i & exceeds(amp_delta_i, amp_ref_i);
        err_set[`RFI_B1] = wake_meas_i & exceeds(phase_delta_i, phase_ref_i);
        err_set[`RFI_B0] = wake_meas_i & exceeds(cap_delta_i, cap_ref_i);
        tgt_set = target_event_i & `RFI_TGT_USED;
    end

    // ----------------------------------------
    // flag registers
    // ----------------------------------------
    assign nxt_main = set_clr(main_ff, main_set, rd_main);
    assign nxt_tmr = set_clr(tmr_ff, tmr_set, rd_tmr);
    assign nxt_err = set_clr(err_ff, err_set, rd_main | rd_err);
    assign nxt_tgt = set_clr(tgt_ff, tgt_set, rd_tgt);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_ff <= `RFI_RST_BYTE;
            tmr_ff <= `RFI_RST_BYTE;
            err_ff <= `RFI_RST_BYTE;
            tgt_ff <= `RFI_RST_BYTE;
        end else begin
            main_ff <= nxt_main;
            tmr_ff <= nxt_tmr;
            err_ff <= nxt_err;
            tgt_ff <= nxt_tgt;
        end
    end

    // ----------------------------------------
    // interrupt request
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(main_ff & ~mask_main_ff) | |(tmr_ff & ~mask_tmr_ff)
                    | |(err_ff & ~mask_err_ff) | |(tgt_ff & ~mask_tgt_ff);
        end
    end

    assign wb_dat_o = dat_ff;
    assign wb_ack_o = ack_ff;
    assign irq_o = irq_ff;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_rd_tmr_quiet;
        rd_tmr && (tmr_set == `RFI_RST_BYTE);
    endsequence

    sequence s_rd_main_quiet;
        rd_main && (err_set == `RFI_RST_BYTE);
    endsequence

    sequence s_bus_cycle;
        bus_req ##1 wb_ack_o;
    endsequence

    AST_MASK_TGT_RESET: assert property (@(posedge clk_i)
        $past(rst_i) |-> (mask_tgt_ff == `RFI_RST_BYTE) && !mask_tgt_ff[`RFI_B2])
        else $error("target mask not zero after reset");

    AST_OSC_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(osc_stable_i) && ctrl_ff[`RFI_CTRL_OSC_EN] |=> main_ff[`RFI_B7])
        else $error("oscillator flag not set");

    AST_WL_RX: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_active_i && (fifo_count_i > `RFI_WL_RX_LIMIT) |=> main_ff[`RFI_B6])
        else $error("receive level flag not set");

    AST_WL_TX: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_active_i && (fifo_count_i < `RFI_WL_TX_LIMIT) |=> main_ff[`RFI_B6])
        else $error("transmit level flag not set");

    AST_DISTURB: assert property (@(posedge clk_i) disable iff (rst_i)
        disturbance_frame_i |=> main_ff[`RFI_B1] && !main_ff[`RFI_B0])
        else $error("restart flag not set");

    AST_TMR_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rd_tmr_quiet |=> (tmr_ff == `RFI_RST_BYTE) ##1 wb_dat_o[7:0] == $past(rd_byte, 2))
        else $error("timer register not cleared on read");

    AST_ERR_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rd_main_quiet |=> (err_ff == `RFI_RST_BYTE))
        else $error("error register not cleared by main read");

    AST_FIELD_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(ext_field_i) |=> tmr_ff[`RFI_B3] && !$past(tmr_set[`RFI_B4]))
        else $error("field drop flag not set");

    AST_WAKE_TIMER: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_timeout_i && !ctrl_ff[`RFI_CTRL_WAKE_EVERY] && !err_ff[`RFI_B3]
        && !rd_main && !rd_err |=> !err_ff[`RFI_B3])
        else $error("wake timer flag set without option");

    AST_TGT_RESERVED: assert property (@(posedge clk_i) disable iff (rst_i)
        !tgt_ff[`RFI_B2] && !mask_tgt_ff[`RFI_B2])
        else $error("reserved target bit set");

    AST_IRQ_RAISE: assert property (@(posedge clk_i) disable iff (rst_i)
        (|(err_ff & ~mask_err_ff)) |=> irq_o)
        else $error("irq not raised for unmasked flag");

    AST_IRQ_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
        ((main_ff & ~mask_main_ff) == `RFI_RST_BYTE) && ((tmr_ff & ~mask_tmr_ff) == `RFI_RST_BYTE)
        && ((err_ff & ~mask_err_ff) == `RFI_RST_BYTE)
        && ((tgt_ff & ~mask_tgt_ff) == `RFI_RST_BYTE) |=> !irq_o)
        else $error("irq raised with all flags masked");

    AST_BUS_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
        s_bus_cycle |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    AST_RD_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_hit |=> wb_ack_o && (wb_dat_o[7:0] == $past(rd_byte)))
        else $error("read data not returned with ack");

    AST_RX_START: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_start_i |=> main_ff[`RFI_B5])
        else $error("receive start flag not set");

    AST_RX_END: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_end_i |=> main_ff[`RFI_B4])
        else $error("receive end flag not set");

    AST_TX_END: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_end_i |=> main_ff[`RFI_B3])
        else $error("transmit end flag not set");

    AST_BIT_COL: assert property (@(posedge clk_i) disable iff (rst_i)
        bit_collision_i |=> main_ff[`RFI_B2] && !main_ff[`RFI_B0])
        else $error("bit collision flag not set");

    AST_CMD_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd_done_i |=> tmr_ff[`RFI_B7])
        else $error("command done flag not set");

    AST_TIMER_EXPIRE: assert property (@(posedge clk_i) disable iff (rst_i)
        nrt_expire_i && gpt_expire_i |=> tmr_ff[`RFI_B6] && tmr_ff[`RFI_B5])
        else $error("timer expiry flags not set");

    AST_CA_COL: assert property (@(posedge clk_i) disable iff (rst_i)
        ca_collision_i |=> tmr_ff[`RFI_B2])
        else $error("avoidance collision flag not set");

    AST_GUARD: assert property (@(posedge clk_i) disable iff (rst_i)
        ca_guard_done_i |=> tmr_ff[`RFI_B1])
        else $error("guard time flag not set");

    AST_BITRATE: assert property (@(posedge clk_i) disable iff (rst_i)
        target_mode_i && bitrate_found_i |=> tmr_ff[`RFI_B0])
        else $error("bit rate flag not set");

    AST_CRC_PARITY: assert property (@(posedge clk_i) disable iff (rst_i)
        crc_err_i && parity_err_i && soft_framing_i |=> err_ff[7:5] == 3'h7)
        else $error("crc, parity or soft framing flag not set");

    AST_HARD_FRAME: assert property (@(posedge clk_i) disable iff (rst_i)
        hard_framing_i |=> err_ff[`RFI_B4])
        else $error("hard framing flag not set");

    AST_AMP_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_meas_i && (amp_delta_i > amp_ref_i) |=> err_ff[`RFI_B2])
        else $error("amplitude wake flag not set");

    AST_PHASE_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_meas_i && (phase_delta_i > phase_ref_i) |=> err_ff[`RFI_B1])
        else $error("phase wake flag not set");

    AST_CAP_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_meas_i && (cap_delta_i > cap_ref_i) |=> err_ff[`RFI_B0])
        else $error("capacitance wake flag not set");

endmodule
`default_nettype wire

// >>> rfi_flags_bench.sv
// self-checking bench of the interrupt flag block
`timescale 1ns/1ps
`default_nettype none
`include "rfi_consts.svh"

module rfi_flags_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, done, go = 1'b0, we = 1'b0;
    logic [9:0] wb_adr_i, adr = '0, fifo_count_i = '0;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [7:0] dat = '0, rdat, pm = '0, pt = '0, pe = '0, target_event_i = '0;
    logic osc_stable_i = 0, rx_active_i = 0, tx_active_i = 0, ext_field_i = 0, target_mode_i = 0;
    logic [7:0] amp_delta_i = '0, amp_ref_i = '0, phase_delta_i = '0, phase_ref_i = '0;
    logic [7:0] cap_delta_i = '0, cap_ref_i = '0;
    logic rx_start_i, rx_end_i, tx_end_i, bit_collision_i, disturbance_frame_i;
    logic cmd_done_i, nrt_expire_i, gpt_expire_i, ca_collision_i, ca_guard_done_i;
    logic bitrate_found_i, crc_err_i, parity_err_i, soft_framing_i, hard_framing_i;
    logic wake_timeout_i, wake_meas_i;
    int num_errors = 0, checked = 0, cycles = 0;
    localparam logic [9:0] LV [4] = '{10'h12c, 10'h12d, 10'h0c8, 10'h0c7};
    localparam logic [7:0] EX [4] = '{8'h00, 8'h40, 8'h00, 8'h40};

    // pulse vectors laid out like the flag registers
    assign {rx_start_i, rx_end_i, tx_end_i, bit_collision_i, disturbance_frame_i} = pm[5:1];
    assign {cmd_done_i, nrt_expire_i, gpt_expire_i} = pt[7:5];
    assign {ca_collision_i, ca_guard_done_i, bitrate_found_i} = pt[2:0];
    assign {crc_err_i, parity_err_i, soft_framing_i, hard_framing_i, wake_timeout_i} = pe[7:3];
    assign wake_meas_i = pe[2];

    always #10 clk_i = ~clk_i;

    rfi_flags u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .osc_stable_i, .rx_active_i, .tx_active_i,
        .fifo_count_i, .rx_start_i, .rx_end_i, .tx_end_i, .bit_collision_i,
        .disturbance_frame_i, .cmd_done_i, .nrt_expire_i, .gpt_expire_i, .ext_field_i,
        .ca_collision_i, .ca_guard_done_i, .target_mode_i, .bitrate_found_i, .crc_err_i,
        .parity_err_i, .soft_framing_i, .hard_framing_i, .wake_timeout_i, .wake_meas_i,
        .amp_delta_i, .amp_ref_i, .phase_delta_i, .phase_ref_i, .cap_delta_i, .cap_ref_i,
        .target_event_i);

    rfi_host u_host (.clk_i, .rst_i, .go_i(go), .we_i(we), .adr_i(adr), .dat_i(dat),
        .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
        .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i),
        .done_o(done), .rdat_o(rdat));

    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        go <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= d;
        tick();
        go <= 1'b0;
        while (done !== 1'b1) begin
            tick();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check($sformatf("reg %h", idx), rdat, exp);
    endtask

    task automatic irqchk(input logic e);
        tick();
        check("irq", {7'h00, irq_o}, {7'h00, e});
    endtask

    task automatic pulse(input logic [7:0] m, t, e, g);
        {pm, pt, pe, target_event_i} <= {m, t, e, g};
        tick();
        {pm, pt, pe, target_event_i} <= '0;
        tick();
    endtask

    task automatic end_of_test();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        tick(3);
        rst_i <= 1'b0;
        tick();
        rd(`RFI_IDX_MASK_TGT, 8'h00);
        wr(`RFI_IDX_MASK_TGT, 8'hff);
        rd(`RFI_IDX_MASK_TGT, 8'hfb);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h00);
        // oscillator edge without enable is ignored
        osc_stable_i <= 1'b1;
        tick();
        osc_stable_i <= 1'b0;
        wr(`RFI_IDX_CTRL, 8'h01);
        osc_stable_i <= 1'b1;
        pulse(8'h3e, 8'h00, 8'hf0, 8'h00);
        irqchk(1'b1);
        rd(`RFI_IDX_MAIN, 8'hbe);
        rd(`RFI_IDX_ERR, 8'h00);
        irqchk(1'b0);
        for (int i = 0; i < 4; i++) begin
            rx_active_i <= (i < 2);
            tx_active_i <= (i >= 2);
            fifo_count_i <= LV[i];
            tick(2);
            {rx_active_i, tx_active_i} <= 2'b00;
            tick();
            rd(`RFI_IDX_MAIN, EX[i]);
        end
        rd(`RFI_IDX_TMR, 8'h00);
        ext_field_i <= 1'b1;
        target_mode_i <= 1'b1;
        pulse(8'h00, 8'he7, 8'h00, 8'h00);
        rd(`RFI_IDX_TMR, 8'hf7);
        rd(`RFI_IDX_TMR, 8'h00);
        ext_field_i <= 1'b0;
        target_mode_i <= 1'b0;
        pulse(8'h00, 8'h01, 8'h00, 8'h00);
        rd(`RFI_IDX_TMR, 8'h08);
        {amp_ref_i, phase_ref_i, cap_ref_i} <= {8'h40, 8'h40, 8'h40};
        {amp_delta_i, phase_delta_i, cap_delta_i} <= {8'h41, 8'h40, 8'h41};
        pulse(8'h00, 8'h00, 8'hfc, 8'h00);
        rd(`RFI_IDX_ERR, 8'hf5);
        rd(`RFI_IDX_ERR, 8'h00);
        wr(`RFI_IDX_CTRL, 8'h03);
        {amp_delta_i, phase_delta_i, cap_delta_i} <= {8'h40, 8'h41, 8'h3f};
        pulse(8'h00, 8'h00, 8'h0c, 8'h00);
        rd(`RFI_IDX_ERR, 8'h0a);
        pulse(8'h10, 8'h00, 8'h00, 8'h00);
        irqchk(1'b1);
        wr(`RFI_IDX_MASK_MAIN, 8'h10);
        irqchk(1'b0);
        wr(`RFI_IDX_MASK_MAIN, 8'h00);
        irqchk(1'b1);
        rd(`RFI_IDX_MAIN, 8'h10);
        irqchk(1'b0);
        wr(`RFI_IDX_MASK_TGT, 8'h00);
        pulse(8'h00, 8'h00, 8'h00, 8'hff);
        irqchk(1'b1);
        wr(`RFI_IDX_MASK_TGT, 8'hfb);
        irqchk(1'b0);
        rd(`RFI_IDX_TGT, 8'hfb);
        rd(`RFI_IDX_TGT, 8'h00);
        wr(`RFI_IDX_MASK_TMR, 8'h80);
        wr(`RFI_IDX_MASK_ERR, 8'h80);
        pulse(8'h00, 8'h80, 8'h80, 8'h00);
        irqchk(1'b0);
        rd(`RFI_IDX_TMR, 8'h80);
        rd(`RFI_IDX_MAIN, 8'h00);
        rd(`RFI_IDX_ERR, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire

// >>> rfi_host.sv
// wishbone host model that issues one register access per request
`timescale 1ns/1ps
`default_nettype none

module rfi_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [7:0] dat_i,
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [9:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    output logic done_o,
    output logic [7:0] rdat_o
);
    assign wb_stb_o = wb_cyc_o;
    assign wb_sel_o = 4'h1;

    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            wb_cyc_o <= 1'b0;
            wb_we_o <= 1'b0;
            wb_adr_o <= 10'h000;
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_o && wb_ack_i) begin
            // released address and data lines never keep the last value
            wb_cyc_o <= 1'b0;
            wb_adr_o <= ~wb_adr_o;
            wb_dat_o <= ~wb_dat_o;
            rdat_o <= wb_dat_i[7:0];
            done_o <= 1'b1;
        end else if (go_i && !wb_cyc_o) begin
            wb_cyc_o <= 1'b1;
            wb_we_o <= we_i;
            wb_adr_o <= adr_i;
            wb_dat_o <= {24'h00_0000, dat_i};
        end
    end
endmodule
`default_nettype wire

// >>> rfi_pkg.sv
// types of the rf front-end interrupt flag block
`default_nettype none
package rfi_pkg;
    typedef logic [7:0] rfi_byte_t;
    typedef logic [7:0] rfi_idx_t;
    typedef logic [9:0] rfi_count_t;
endpackage
`default_nettype wire
